// ===== include/decode_pkg.sv
// Package: opcodes, rotate selectors and cycle-count constants for the string/rotate decoder
package decode_pkg;
  localparam logic [7:0] OP_ROT8_ONCE = 8'hD0; // Rotate byte once
  localparam logic [7:0] OP_ROT16_ONCE = 8'hD1; // Rotate word once
  localparam logic [7:0] OP_ROT8_CNT = 8'hD2; // Rotate byte by count register
  localparam logic [7:0] OP_ROT16_CNT = 8'hD3; // Rotate word by count register
  localparam logic [7:0] OP_ROT8_IMM = 8'hC0; // Rotate byte by immediate
  localparam logic [7:0] OP_ROT16_IMM = 8'hC1; // Rotate word by immediate
  localparam logic [2:0] REG_LEFT = 3'h2; // Reg field for left rotate
  localparam logic [2:0] REG_RIGHT = 3'h3; // Reg field for right rotate
  localparam logic [7:0] OP_LOOP_PREFIX = 8'hF3; // Loop prefix byte
  localparam logic [7:0] OP_COPY_B = 8'hA4;
  localparam logic [7:0] OP_COPY_W = 8'hA5;
  localparam logic [7:0] OP_CMP_B = 8'hA6;
  localparam logic [7:0] OP_CMP_W = 8'hA7;
  localparam logic [7:0] OP_FILL_B = 8'hAA;
  localparam logic [7:0] OP_FILL_W = 8'hAB;
  localparam logic [7:0] OP_LOAD_B = 8'hAC;
  localparam logic [7:0] OP_LOAD_W = 8'hAD;
  localparam logic [7:0] OP_SCAN_B = 8'hAE;
  localparam logic [7:0] OP_SCAN_W = 8'hAF;
  localparam logic [7:0] OP_IN_B = 8'h6C;
  localparam logic [7:0] OP_IN_W = 8'h6D;
  localparam logic [7:0] OP_OUT_B = 8'h6E;
  localparam logic [7:0] OP_OUT_W = 8'h6F;
  localparam logic [7:0] OP_PUSH_FLAGS = 8'h9C;
  // Cycle counts
  localparam logic [15:0] CYC_ROT1_REG = 16'h0002;
  localparam logic [15:0] CYC_ROT1_MEM = 16'h000F;
  localparam logic [15:0] CYC_ROTN_REG = 16'h0005;
  localparam logic [15:0] CYC_ROTN_MEM = 16'h0011;
  localparam logic [15:0] CYC_MOVE_BASE = 16'h0008;
  localparam logic [15:0] CYC_MOVE_BASE_W8 = 16'h000C;
  localparam logic [15:0] CYC_MOVE_PER = 16'h0008;
  localparam logic [15:0] CYC_LOAD_BASE = 16'h0006;
  localparam logic [15:0] CYC_LOAD_BASE_W8 = 16'h000A;
  localparam logic [15:0] CYC_LOAD_PER = 16'h000B;
  localparam logic [15:0] CYC_SRCH_BASE = 16'h0005;
  localparam logic [15:0] CYC_SRCH_BASE_W8 = 16'h0009;
  localparam logic [15:0] CYC_CMP_PER = 16'h0016;
  localparam logic [15:0] CYC_SCAN_PER = 16'h000F;
  localparam logic [15:0] CYC_PUSH_STATUS_FLAGS_16 = 16'h0009;
  localparam logic [15:0] CYC_PUSH_STATUS_FLAGS_8 = 16'h000D;
  // Operation kinds
  typedef enum logic [3:0] {
    K_NONE = 4'h0, K_RCL = 4'h1, K_RCR = 4'h2, K_COPY = 4'h3, K_FILL = 4'h4,
    K_LOAD = 4'h5, K_IN = 4'h6, K_OUT = 4'h7, K_CMP = 4'h8, K_SCAN = 4'h9,
    K_PUSH_STATUS_FLAGS = 4'hA
  } kind_e;
endpackage : decode_pkg

// ===== verilog/string_rotate_decoder.sv
// String, rotate-through-carry and push-flags decoder with cycle timing
`timescale 1ns/1ps
// How it works
// [RQ1] D0/D2/C0 reg 2 byte left rotate
// [RQ2] D1/D3/C1 reg 2 word 17-bit rotate
// [RQ3] Same opcodes, reg 3, right rotate
// [RQ4] Multi rotate: 5+n reg, 17+n mem
// [RQ5] F3 A4/A5 copy, 8+8n or 12+8n
// [RQ6] F3 AA/AB fill accumulator, 8+8n/12+8n
// [RQ7] F3 AC/AD load accumulator, 6+11n/10+11n
// [RQ8] F3 6D port input, 8+8n/12+8n
// [RQ9] F3 6E/6F port output, 8+8n/12+8n
// [RQ10] F3 A6/A7 compare, 5+22n/9+22n
// [RQ11] F3 AE/AF scan, 5+15n/9+15n
// [RQ12] 9C pushes flags, 9 or 13
// [RQ13] Stream never holds zero short jump
// [RQ14] Repeat while count nonzero, decrement each
// [RQ15] Compare/scan stop early on mismatch, zero flag
module string_rotate_decoder #(
  parameter int CNT_W = 16 // Count register width
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Instruction in
  input wire logic start, // One-cycle pulse: instruction present
  input wire logic [7:0] op_byte1, // First byte (prefix or opcode)
  input wire logic [7:0] op_byte2, // Second byte (opcode or modrm)
  input wire logic [7:0] imm_count, // Immediate rotate count
  input wire logic narrow_bus, // High on the 8-bit bus variant
  input wire logic [CNT_W-1:0] count_in, // Count register value
  input wire logic [16:0] rot_in, // Carry in bit 16, operand below
  // Element compare result from the datapath
  input wire logic elem_match, // Current element equals its partner
  // Outputs
  output logic busy, // Instruction in progress
  output logic done, // One-cycle end pulse
  output logic illegal, // Opcode not recognised by this block
  output decode_pkg::kind_e kind, // Decoded operation
  output logic is_word, // Word form
  output logic elem_strobe, // One element processed this cycle
  output logic [CNT_W-1:0] count_out, // Count register as it runs
  output logic zero_flag, // Result of last compare
  output logic [16:0] rot_out, // Rotated carry and operand
  output logic [15:0] cycles // Cycles the instruction took
);
  import decode_pkg::*;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_BASE = 2'b01, S_ELEM = 2'b10, S_DONE = 2'b11
  } state_e;

  state_e state_reg, state_next; // Sequencer state
  kind_e kind_reg, kind_next; // Decoded kind
  logic word_reg, word_next; // Word form flag
  logic mem_reg, mem_next; // Memory operand
  logic [15:0] wait_reg, wait_next; // Cycles left in current phase
  logic [15:0] per_reg, per_next; // Cycles per element
  logic [15:0] total_reg, total_next; // Cycle tally
  logic [CNT_W-1:0] cnt_reg, cnt_next; // Working count
  logic [7:0] rcnt_reg, rcnt_next; // Rotate steps left
  logic [16:0] rot_reg, rot_next; // Rotate working value
  logic zf_reg, zf_next; // Zero flag
  logic done_reg, done_next; // Done pulse
  logic ill_reg, ill_next; // Illegal flag
  logic strobe_reg, strobe_next; // Element strobe
  logic busy_reg, busy_next; // Busy flag

  // One rotate step through carry over 9 or 17 bits
  function automatic logic [16:0] rot_step(input logic [16:0] v, input logic left,
                                           input logic wide);
    logic [16:0] r;
    r = v;
    if (wide) begin
      r = left ? {v[15:0], v[16]} : {v[0], v[16:1]};
    end else if (left) begin
      r = {v[7], 8'h00, v[6:0], v[16]};
    end else begin
      r = {v[0], 8'h00, v[16], v[7:1]};
    end
    return r;
  endfunction : rot_step

  // Base cycles that pick the narrow-bus word variant
  function automatic logic [15:0] pick(input logic w8, input logic [15:0] a,
                                       input logic [15:0] b);
    return w8 ? b : a;
  endfunction : pick

  // Next-state logic
  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    word_next = word_reg;
    mem_next = mem_reg;
    wait_next = wait_reg;
    per_next = per_reg;
    total_next = total_reg;
    cnt_next = cnt_reg;
    rcnt_next = rcnt_reg;
    rot_next = rot_reg;
    zf_next = zf_reg;
    done_next = 1'b0;
    ill_next = ill_reg;
    strobe_next = 1'b0;
    busy_next = busy_reg;
    case (state_reg)
      S_IDLE: begin
        if (start) begin
          // Decode
          ill_next = 1'b0;
          total_next = 16'h0000;
          cnt_next = count_in;
          rot_next = rot_in;
          mem_next = (op_byte2[7:6] != 2'b11);
          word_next = 1'b0;
          kind_next = K_NONE;
          wait_next = 16'h0001;
          per_next = 16'h0000;
          rcnt_next = 8'h00;
          state_next = S_BASE;
          busy_next = 1'b1;
          if (op_byte1 == OP_PUSH_FLAGS) begin
            kind_next = K_PUSH_STATUS_FLAGS;
            wait_next = pick(narrow_bus, CYC_PUSH_STATUS_FLAGS_16, CYC_PUSH_STATUS_FLAGS_8); // RQ12
          end else if ((op_byte1[7:4] == 4'hD && op_byte1[3:2] == 2'b00) ||
                       op_byte1[7:1] == 7'b1100000) begin
            word_next = op_byte1[0]; // RQ2
            if (op_byte2[5:3] == REG_LEFT) begin
              kind_next = K_RCL; // RQ1
            end else if (op_byte2[5:3] == REG_RIGHT) begin
              kind_next = K_RCR; // RQ3
            end
            if (op_byte1 == OP_ROT8_ONCE || op_byte1 == OP_ROT16_ONCE) begin
              rcnt_next = 8'h01;
              wait_next = (op_byte2[7:6] != 2'b11) ? CYC_ROT1_MEM : CYC_ROT1_REG; // RQ1
            end else begin
              rcnt_next = (op_byte1[7:4] == 4'hD) ? count_in[7:0] : imm_count;
              // RQ4
              wait_next = ((op_byte2[7:6] != 2'b11) ? CYC_ROTN_MEM : CYC_ROTN_REG) +
                          16'((op_byte1[7:4] == 4'hD) ? count_in[7:0] : imm_count);
            end
          end else if (op_byte1 == OP_LOOP_PREFIX) begin
            word_next = op_byte2[0];
            // Copy, fill and port forms share the move timing
            per_next = CYC_MOVE_PER;
            wait_next = pick(narrow_bus & op_byte2[0], CYC_MOVE_BASE, CYC_MOVE_BASE_W8);
            case (op_byte2)
              OP_COPY_B, OP_COPY_W: kind_next = K_COPY; // RQ5
              OP_FILL_B, OP_FILL_W: kind_next = K_FILL; // RQ6
              OP_LOAD_B, OP_LOAD_W: begin
                kind_next = K_LOAD; // RQ7
                per_next = CYC_LOAD_PER;
                wait_next = pick(narrow_bus & op_byte2[0], CYC_LOAD_BASE, CYC_LOAD_BASE_W8);
              end
              OP_IN_B, OP_IN_W: kind_next = K_IN; // RQ8
              OP_OUT_B, OP_OUT_W: kind_next = K_OUT; // RQ9
              OP_CMP_B, OP_CMP_W: begin
                kind_next = K_CMP; // RQ10
                per_next = CYC_CMP_PER;
                wait_next = pick(narrow_bus & op_byte2[0], CYC_SRCH_BASE, CYC_SRCH_BASE_W8);
              end
              OP_SCAN_B, OP_SCAN_W: begin
                kind_next = K_SCAN; // RQ11
                per_next = CYC_SCAN_PER;
                wait_next = pick(narrow_bus & op_byte2[0], CYC_SRCH_BASE, CYC_SRCH_BASE_W8);
              end
              default: kind_next = K_NONE; // Unknown string opcode
            endcase
          end
          if (kind_next == K_NONE) begin
            // Unknown opcode: flag and finish at once
            ill_next = 1'b1;
            busy_next = 1'b0;
            done_next = 1'b1;
            state_next = S_IDLE;
          end
        end
      end
      S_BASE: begin
        // Base cycles; rotates shift one step per cycle meanwhile
        total_next = total_reg + 16'h0001;
        if ((kind_reg == K_RCL || kind_reg == K_RCR) && rcnt_reg != 8'h00) begin
          rot_next = rot_step(rot_reg, kind_reg == K_RCL, word_reg); // RQ1
          rcnt_next = rcnt_reg - 8'h01;
        end
        if (wait_reg <= 16'h0001) begin
          if (per_reg != 16'h0000 && cnt_reg != '0) begin
            state_next = S_ELEM; // RQ14
            wait_next = per_reg;
          end else begin
            state_next = S_DONE;
          end
        end else begin
          wait_next = wait_reg - 16'h0001;
        end
      end
      S_ELEM: begin
        // One element per pass
        total_next = total_reg + 16'h0001;
        if (wait_reg <= 16'h0001) begin
          strobe_next = 1'b1;
          cnt_next = cnt_reg - 1'b1; // RQ14
          wait_next = per_reg;
          if (kind_reg == K_CMP || kind_reg == K_SCAN) begin
            zf_next = elem_match; // RQ15
          end
          if (cnt_reg == CNT_W'(1) ||
              ((kind_reg == K_CMP || kind_reg == K_SCAN) && !elem_match)) begin
            state_next = S_DONE; // RQ15
          end
        end else begin
          wait_next = wait_reg - 16'h0001;
        end
      end
      S_DONE: begin
        done_next = 1'b1;
        busy_next = 1'b0;
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // Registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= S_IDLE;
      kind_reg <= K_NONE;
      word_reg <= 1'b0;
      mem_reg <= 1'b0;
      wait_reg <= 16'h0000;
      per_reg <= 16'h0000;
      total_reg <= 16'h0000;
      cnt_reg <= '0;
      rcnt_reg <= 8'h00;
      rot_reg <= 17'h00000;
      zf_reg <= 1'b0;
      done_reg <= 1'b0;
      ill_reg <= 1'b0;
      strobe_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      word_reg <= word_next;
      mem_reg <= mem_next;
      wait_reg <= wait_next;
      per_reg <= per_next;
      total_reg <= total_next;
      cnt_reg <= cnt_next;
      rcnt_reg <= rcnt_next;
      rot_reg <= rot_next;
      zf_reg <= zf_next;
      done_reg <= done_next;
      ill_reg <= ill_next;
      strobe_reg <= strobe_next;
      busy_reg <= busy_next;
    end
  end

  // Outputs straight from flip-flops
  assign busy = busy_reg;
  assign done = done_reg;
  assign illegal = ill_reg;
  assign kind = kind_reg;
  assign is_word = word_reg;
  assign elem_strobe = strobe_reg;
  assign count_out = cnt_reg;
  assign zero_flag = zf_reg;
  assign rot_out = rot_reg;
  assign cycles = total_reg;

  // Checks
  property p_push_status_flags_time;
    @(posedge clk) disable iff (reset)
      (start && !busy && op_byte1 == OP_PUSH_FLAGS && !narrow_bus) |=> ##10 done;
  endproperty
  a_push_status_flags_time: assert property (p_push_status_flags_time) else $error("push flags not 9 cycles"); // RQ12

  property p_push_status_flags_narrow;
    @(posedge clk) disable iff (reset)
      (start && !busy && op_byte1 == OP_PUSH_FLAGS && narrow_bus)
      |=> ##14 (done && cycles == CYC_PUSH_STATUS_FLAGS_8);
  endproperty
  a_push_status_flags_narrow: assert property (p_push_status_flags_narrow) else $error("push flags not 13 cycles"); // RQ12

  property p_rot_once_reg;
    @(posedge clk) disable iff (reset)
      (start && !busy && op_byte1 == OP_ROT8_ONCE && op_byte2[7:6] == 2'b11 &&
       op_byte2[5:3] == REG_LEFT) |=> (kind == K_RCL) ##3 done;
  endproperty
  a_rot_once_reg: assert property (p_rot_once_reg) else $error("rotate once not 2 cycles"); // RQ1

  property p_rot_right_kind;
    @(posedge clk) disable iff (reset)
      (start && !busy && op_byte1 == OP_ROT16_CNT && op_byte2[5:3] == REG_RIGHT)
      |=> (kind == K_RCR && is_word);
  endproperty
  a_rot_right_kind: assert property (p_rot_right_kind) else $error("right rotate decode"); // RQ3

  property p_rotn_cycles;
    @(posedge clk) disable iff (reset)
      (done && (kind == K_RCL || kind == K_RCR) && !mem_reg && $past(state_reg) == S_DONE &&
       rcnt_reg == 8'h00 && cycles > 16'h0002) |-> cycles >= CYC_ROTN_REG;
  endproperty
  a_rotn_cycles: assert property (p_rotn_cycles) else $error("multi rotate too short"); // RQ4

  property p_count_dec;
    @(posedge clk) disable iff (reset)
      elem_strobe |-> count_out == $past(cnt_reg) - 1'b1;
  endproperty
  a_count_dec: assert property (p_count_dec) else $error("count not decremented"); // RQ14

  sequence s_mismatch;
    elem_strobe && (kind == K_CMP || kind == K_SCAN) && !zero_flag;
  endsequence
  property p_early_stop;
    @(posedge clk) disable iff (reset)
      s_mismatch |=> (done && !elem_strobe);
  endproperty
  a_early_stop: assert property (p_early_stop) else $error("no stop on mismatch"); // RQ15

  property p_copy_base;
    @(posedge clk) disable iff (reset)
      (start && !busy && op_byte1 == OP_LOOP_PREFIX && op_byte2 == OP_COPY_B && count_in == '0)
      |=> ##9 (done && cycles == CYC_MOVE_BASE);
  endproperty
  a_copy_base: assert property (p_copy_base) else $error("copy base not 8 cycles"); // RQ5

  property p_elem_spacing;
    @(posedge clk) disable iff (reset)
      (elem_strobe && kind == K_FILL && busy && count_out != '0)
      |=> !elem_strobe [*7] ##1 elem_strobe;
  endproperty
  a_elem_spacing: assert property (p_elem_spacing) else $error("fill not 8 per element"); // RQ6

endmodule : string_rotate_decoder

// ===== bench/test_rotate_carry_and_repeat_string_decode.sv
// Self-checking bench for the string, rotate-through-carry and push-flags decoder
`timescale 1ns/1ps
module test_rotate_carry_and_repeat_string_decode;
  import decode_pkg::*;
  // Compare one value, count it, report a mismatch
  `define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
  // One table row: inputs and the kind they should decode to
  typedef struct {logic [7:0] b1; logic [7:0] b2; logic [7:0] imm; logic nb;
    logic [15:0] cnt; logic m; kind_e k;} row_s;
  // Design ports
  logic clk, reset, start, narrow_bus, elem_match;
  logic busy, done, illegal, is_word, elem_strobe, zero_flag;
  logic [7:0] op_byte1, op_byte2, imm_count;
  logic [15:0] count_in, count_out, cycles;
  logic [16:0] rot_in, rot_out;
  kind_e kind;
  // Bench bookkeeping
  int errors = 0;
  int tests_run = 0;
  row_s rows[$];

  string_rotate_decoder #(.CNT_W(16)) u_string_rotate_decoder (
    .clk(clk), .reset(reset), .start(start), .op_byte1(op_byte1), .op_byte2(op_byte2),
    .imm_count(imm_count), .narrow_bus(narrow_bus), .count_in(count_in), .rot_in(rot_in),
    .elem_match(elem_match), .busy(busy), .done(done), .illegal(illegal), .kind(kind),
    .is_word(is_word), .elem_strobe(elem_strobe), .count_out(count_out),
    .zero_flag(zero_flag), .rot_out(rot_out), .cycles(cycles));

  // 20 MHz clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // Rotate count of a rotate row
  function automatic int rot_n(row_s r);
    if (r.b1 == OP_ROT8_ONCE || r.b1 == OP_ROT16_ONCE) return 1;
    return (r.b1 == OP_ROT8_IMM || r.b1 == OP_ROT16_IMM) ? int'(r.imm) : int'(r.cnt[7:0]);
  endfunction : rot_n

  // Elements a string row should process
  function automatic int elems(row_s r);
    if ((r.k == K_CMP || r.k == K_SCAN) && !r.m && r.cnt != 16'h0000) return 1;
    return (r.k >= K_COPY && r.k <= K_SCAN) ? int'(r.cnt) : 0;
  endfunction : elems

  // Expected cycle count from the timing formulas
  function automatic int exp_cyc(row_s r, int n);
    logic w8;
    logic mem;
    logic once;
    w8 = r.b2[0] && r.nb;
    mem = r.b2[7:6] != 2'h3;
    once = r.b1 == OP_ROT8_ONCE || r.b1 == OP_ROT16_ONCE;
    case (r.k)
      K_PUSH_STATUS_FLAGS: return r.nb ? CYC_PUSH_STATUS_FLAGS_8 : CYC_PUSH_STATUS_FLAGS_16;
      K_RCL, K_RCR: begin
        if (once) return mem ? CYC_ROT1_MEM : CYC_ROT1_REG;
        return (mem ? CYC_ROTN_MEM : CYC_ROTN_REG) + rot_n(r);
      end
      K_LOAD: return (w8 ? CYC_LOAD_BASE_W8 : CYC_LOAD_BASE) + CYC_LOAD_PER * n;
      K_CMP: return (w8 ? CYC_SRCH_BASE_W8 : CYC_SRCH_BASE) + CYC_CMP_PER * n;
      K_SCAN: return (w8 ? CYC_SRCH_BASE_W8 : CYC_SRCH_BASE) + CYC_SCAN_PER * n;
      default: return (w8 ? CYC_MOVE_BASE_W8 : CYC_MOVE_BASE) + CYC_MOVE_PER * n;
    endcase
  endfunction : exp_cyc

  // Carry-and-operand rotation, 9 or 17 bits wide
  function automatic logic [16:0] rot_model(logic [16:0] v, int n, logic left, logic w);
    logic [8:0] b;
    logic [16:0] x;
    b = {v[16], v[7:0]};
    x = v;
    for (int i = 0; i < n; i++) begin
      x = left ? {x[15:0], x[16]} : {x[0], x[16:1]};
      b = left ? {b[7:0], b[8]} : {b[0], b[8:1]};
    end
    return w ? x : {b[8], v[15:8], b[7:0]};
  endfunction : rot_model

  // Queue one table row
  task automatic add(logic [7:0] b1, logic [7:0] b2, logic [7:0] imm, logic nb,
    logic [15:0] cnt, logic m, kind_e k);
    row_s r;
    r = '{b1, b2, imm, nb, cnt, m, k};
    rows.push_back(r);
  endtask : add

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  // Outputs cleared by reset
  task automatic chk_zero();
    `CHK("busy", 1'h0, busy)
    `CHK("done", 1'h0, done)
    `CHK("count_out", 16'h0000, count_out)
    `CHK("cycles", 16'h0000, cycles)
    $display("test reset finished");
  endtask : chk_zero

  // Run one instruction; drop: element after which the match fails, poke: start while busy
  task automatic do_row(row_s r, int drop, logic poke);
    int lat;
    int st;
    int n;
    int ec;
    logic [16:0] er;
    logic [16:0] mk;
    lat = 0;
    st = 0;
    n = drop > 0 ? drop + 1 : elems(r);
    ec = exp_cyc(r, n);
    er = rot_model({r.cnt[0], 16'hB2C5 ^ r.cnt}, rot_n(r), r.k == K_RCL, r.b1[0]);
    mk = r.b1[0] ? 17'h1FFFF : 17'h100FF;
    @(posedge clk);
    start <= 1'h1;
    op_byte1 <= r.b1;
    op_byte2 <= r.b2;
    imm_count <= r.imm;
    narrow_bus <= r.nb;
    count_in <= r.cnt;
    elem_match <= r.m;
    rot_in <= {r.cnt[0], 16'hB2C5 ^ r.cnt};
    @(posedge clk);
    start <= 1'h0;
    // Look after the taking edge: an unknown opcode finishes right there
    #1;
    for (int i = 0; i < 3000 && done !== 1'h1; i++) begin
      @(posedge clk);
      start <= poke && lat == 3;
      if (poke && lat == 3) op_byte1 <= 8'h90;
      if (drop > 0 && st == drop) elem_match <= 1'h0;
      #1;
      lat++;
      if (elem_strobe === 1'h1) st++;
    end
    if (done !== 1'h1) begin
      errors++;
      $display("mismatch done expected 1 seen %b", done);
      end_sim();
    end
    $display("test %s %0h %0h finished", r.k.name(), r.b1, r.b2);
    if (r.k == K_NONE) begin
      `CHK("illegal", 1'h1, illegal)
      `CHK("latency", 0, lat)
      return;
    end
    `CHK("illegal", 1'h0, illegal)
    `CHK("kind", r.k, kind)
    `CHK("latency", ec + 1, lat)
    `CHK("cycles", ec[15:0], cycles)
    `CHK("busy", 1'h0, busy)
    if (r.k != K_PUSH_STATUS_FLAGS) `CHK("is_word", r.k <= K_RCR ? r.b1[0] : r.b2[0], is_word)
    if (r.k <= K_RCR) `CHK("rot_out", er & mk, rot_out & mk)
    if (r.k >= K_COPY && r.k <= K_SCAN) begin
      `CHK("strobes", n, st)
      `CHK("count_out", r.cnt - n[15:0], count_out)
    end
    if ((r.k == K_CMP || r.k == K_SCAN) && n > 0) begin
      `CHK("zero_flag", drop == 0 && r.m, zero_flag)
    end
  endtask : do_row

  // Main sequence
  initial begin
    reset = 1'h1;
    start = 1'h0;
    narrow_bus = 1'h0;
    elem_match = 1'h0;
    op_byte1 = 8'h00;
    op_byte2 = 8'h00;
    imm_count = 8'h00;
    count_in = 16'h0000;
    rot_in = 17'h00000;
    add(8'hD0, 8'hD0, 8'h00, 1'h0, 16'h0000, 1'h0, K_RCL);
    add(8'hD0, 8'h1E, 8'h00, 1'h0, 16'h0000, 1'h0, K_RCR);
    add(8'hD1, 8'hD8, 8'h00, 1'h0, 16'h0000, 1'h0, K_RCR);
    add(8'hD1, 8'h16, 8'h00, 1'h0, 16'h0000, 1'h0, K_RCL);
    add(8'hD2, 8'hD0, 8'h00, 1'h0, 16'h0003, 1'h0, K_RCL);
    add(8'hD2, 8'h1E, 8'h00, 1'h0, 16'h000A, 1'h0, K_RCR);
    add(8'hD3, 8'hD8, 8'h00, 1'h0, 16'hFF11, 1'h0, K_RCR);
    add(8'hD3, 8'h16, 8'h00, 1'h0, 16'h0000, 1'h0, K_RCL);
    add(8'hC0, 8'hD8, 8'h05, 1'h0, 16'h0007, 1'h0, K_RCR);
    add(8'hC0, 8'h16, 8'hFF, 1'h0, 16'h0001, 1'h0, K_RCL);
    add(8'hC1, 8'hD0, 8'h01, 1'h0, 16'h0002, 1'h0, K_RCL);
    add(8'hC1, 8'h1E, 8'h12, 1'h0, 16'h0005, 1'h0, K_RCR);
    add(8'hD0, 8'hC0, 8'h00, 1'h0, 16'h0000, 1'h0, K_NONE);
    add(8'hC1, 8'hE8, 8'h01, 1'h0, 16'h0000, 1'h0, K_NONE);
    add(8'h9C, 8'h00, 8'h00, 1'h0, 16'h0000, 1'h0, K_PUSH_STATUS_FLAGS);
    add(8'h9C, 8'h00, 8'h00, 1'h1, 16'h0000, 1'h0, K_PUSH_STATUS_FLAGS);
    add(8'hF3, 8'hA4, 8'h00, 1'h0, 16'h0003, 1'h0, K_COPY);
    add(8'hF3, 8'hA4, 8'h00, 1'h0, 16'h0000, 1'h0, K_COPY);
    add(8'hF3, 8'hA5, 8'h00, 1'h1, 16'h0002, 1'h0, K_COPY);
    add(8'hF3, 8'hA5, 8'h00, 1'h0, 16'h0001, 1'h0, K_COPY);
    add(8'hF3, 8'hAA, 8'h00, 1'h0, 16'h0002, 1'h0, K_FILL);
    add(8'hF3, 8'hAB, 8'h00, 1'h1, 16'h0000, 1'h0, K_FILL);
    add(8'hF3, 8'hAC, 8'h00, 1'h1, 16'h0002, 1'h0, K_LOAD);
    add(8'hF3, 8'hAD, 8'h00, 1'h1, 16'h0003, 1'h0, K_LOAD);
    add(8'hF3, 8'h6C, 8'h00, 1'h0, 16'h0002, 1'h0, K_IN);
    add(8'hF3, 8'h6D, 8'h00, 1'h1, 16'h0002, 1'h0, K_IN);
    add(8'hF3, 8'h6E, 8'h00, 1'h1, 16'h0001, 1'h0, K_OUT);
    add(8'hF3, 8'h6F, 8'h00, 1'h1, 16'h0002, 1'h0, K_OUT);
    add(8'hF3, 8'hA6, 8'h00, 1'h0, 16'h0003, 1'h1, K_CMP);
    add(8'hF3, 8'hA7, 8'h00, 1'h1, 16'h0004, 1'h0, K_CMP);
    add(8'hF3, 8'hAE, 8'h00, 1'h0, 16'h0002, 1'h0, K_SCAN);
    add(8'hF3, 8'hAF, 8'h00, 1'h1, 16'h0003, 1'h1, K_SCAN);
    add(8'hF3, 8'h90, 8'h00, 1'h0, 16'h0002, 1'h0, K_NONE);
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    #1;
    chk_zero();
    // No row carries a short jump of zero offset
    foreach (rows[i]) do_row(rows[i], 0, 1'h0);
    // Start while busy must be ignored
    do_row('{8'h9C, 8'h00, 8'h00, 1'h0, 16'h0000, 1'h0, K_PUSH_STATUS_FLAGS}, 0, 1'h1);
    // Compare fails on the second of five elements
    do_row('{8'hF3, 8'hA6, 8'h00, 1'h0, 16'h0005, 1'h1, K_CMP}, 1, 1'h0);
    // Reset in the middle of a long copy
    @(posedge clk);
    start <= 1'h1;
    op_byte1 <= OP_LOOP_PREFIX;
    op_byte2 <= OP_COPY_B;
    count_in <= 16'h0040;
    @(posedge clk);
    start <= 1'h0;
    repeat (20) @(posedge clk);
    reset <= 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    #1;
    chk_zero();
    // First instruction after the mid-run reset
    do_row(rows[0], 0, 1'h0);
    end_sim();
  end
endmodule : test_rotate_carry_and_repeat_string_decode
